// ==== hdl/mmd_pkg.sv ====
// Purpose: Constants for the memory-mode and external select decode block
// Assumes: 10 MHz system clock, 14-bit external address
// Notes:   Register map offsets and fields for the plain register port
package mmd_pkg;
    localparam int          ADDR_W          = 14;
    localparam int          DATA_W          = 16;
    localparam int          REG_AW          = 4;
    // Register offsets
    localparam logic [3:0]  OFS_STATUS      = 4'h0;
    localparam logic [3:0]  OFS_PM_OVLAY    = 4'h1;
    localparam logic [3:0]  OFS_DM_OVLAY    = 4'h2;
    localparam logic [3:0]  OFS_WAIT        = 4'h3;
    localparam logic [3:0]  OFS_CMS_EN      = 4'h4;
    localparam logic [3:0]  OFS_SYSCTL      = 4'h5;
    localparam logic [3:0]  OFS_FLAG        = 4'h6;
    localparam logic [3:0]  OFS_BOOT        = 4'h7;
    // Composite enable bit positions
    localparam int          CMS_PM_BIT      = 0;
    localparam int          CMS_DM_BIT      = 1;
    localparam int          CMS_BM_BIT      = 2;
    localparam int          CMS_IO_BIT      = 3;
    localparam logic [3:0]  CMS_EN_RESET    = 4'hb;
    localparam int          SYSCTL_BMS_DIS  = 3;
    // Overlay and boot figures
    localparam logic [1:0]  OVL_INTERNAL    = 2'h0;
    localparam logic [1:0]  OVL_EXT1        = 2'h1;
    localparam logic [1:0]  OVL_EXT2        = 2'h2;
    localparam logic [13:0] OVL_WIN_LO      = 14'h2000;
    localparam logic [13:0] OVL_WIN_HI      = 14'h3fff;
    localparam int          OVL_LSB_W       = 13;
    localparam int          BOOT_WORDS      = 32;
    localparam int          IO_AW           = 11;
    localparam int          IO_REGION_LSB   = 9;
    localparam logic [13:0] DM_USER_TOP     = 14'h3fdf;
    localparam int          WAIT_W          = 3;
    // Access sequencer states
    typedef enum logic [2:0] {
        MMD_IDLE = 3'b001,
        MMD_WAIT = 3'b010,
        MMD_DONE = 3'b100
    } mmd_acc_e;
endpackage

// ==== hdl/mmd_decode.sv ====
// Purpose: Strap capture, boot hold-off, overlay decode, wait states, selects
// Assumes: Core access requests are one cycle; straps stable during reset
// Notes:   Selects are active-low outputs, all from flip-flops
`timescale 1ns/100ps
module mmd_decode
    import mmd_pkg::*;
#(
    parameter int BOOT_LEN = BOOT_WORDS
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // Strap and flag pins
    input  wire logic              shared_flag_pin_in,
    output logic                   shared_flag_pin_out,
    output logic                   shared_flag_pin_oe,
    input  wire logic              strap_autoboot_n,
    input  wire logic              strap_boot_src,
    // Register port
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Core access request
    input  wire logic              acc_req,
    input  wire logic [1:0]        acc_space,
    input  wire logic [ADDR_W-1:0] acc_addr,
    input  wire logic              bus_request,
    output logic                   acc_done,
    // Boot progress
    input  wire logic              boot_word_loaded,
    input  wire logic              host_pm0_write,
    output logic                   core_run,
    // External bus
    output logic      [ADDR_W-1:0] ext_addr,
    output logic                   program_space_select_n,
    output logic                   data_space_select_n,
    output logic                   boot_space_select_n,
    output logic                   io_space_select_n,
    output logic                   composite_select_n
);
    // Access space codes on acc_space
    localparam logic [1:0] SP_PM = 2'h0;
    localparam logic [1:0] SP_DM = 2'h1;
    localparam logic [1:0] SP_BM = 2'h2;
    localparam logic [1:0] SP_IO = 2'h3;

    // Captured straps and frozen configuration
    logic                  mode_host;
    logic                  no_autoboot;
    logic                  src_host;
    logic                  cap_mode;
    logic                  cap_auto;
    logic                  cap_src;
    logic                  boot_started;

    // Software settings
    logic [1:0]            program_overlay_select;
    logic [1:0]            data_overlay_select;
    logic [WAIT_W-1:0]     data_space_wait_count;
    logic [4*WAIT_W-1:0]   io_region_wait_counts;
    logic [3:0]            composite_select_enables;
    logic                  bms_disable;
    logic                  flag_dir_out;
    logic                  flag_val;

    // Boot hold-off
    logic [5:0]            boot_cnt;
    logic                  boot_hold;

    // Access sequencer
    mmd_acc_e              st;
    logic [WAIT_W-1:0]     wcnt;

    // Request decode
    logic [WAIT_W-1:0]     next_wait;
    logic                  ext_hit;
    logic [3:0]            next_sel;
    logic [ADDR_W-1:0]     next_addr;
    logic [1:0]            ovl;
    logic [1:0]            io_region;
    logic                  in_win;

    // Strap capture while reset is low; registers hold after release
    always_ff @(posedge clk_sys) begin
        if (!arst_n) begin
            cap_mode <= shared_flag_pin_in;
            cap_auto <= strap_autoboot_n;
            cap_src  <= strap_boot_src;
        end
    end

    // Configuration taken from the captured straps at release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_host   <= 1'b0;
            no_autoboot <= 1'b0;
            src_host    <= 1'b0;
        end else if (!boot_started) begin
            mode_host   <= cap_mode;
            no_autoboot <= cap_auto;
            src_host    <= cap_src;
        end
    end

    // One-shot marker that the configuration has been frozen
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            boot_started <= 1'b0;
        end else begin
            boot_started <= 1'b1;
        end
    end

    // Boot hold-off: byte DMA word count or host write of location 0
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            boot_cnt  <= 6'h00;
            boot_hold <= 1'b1;
        end else if (!boot_started) begin
            boot_hold <= !cap_auto;
        end else if (boot_hold) begin
            if (src_host) begin
                if (host_pm0_write) begin
                    boot_hold <= 1'b0;
                end
            end else if (boot_word_loaded) begin
                boot_cnt <= boot_cnt + 6'h01;
                if (boot_cnt == 6'(BOOT_LEN - 1)) begin
                    boot_hold <= 1'b0;
                end
            end
        end
    end

    // Execution enable out of the boot hold-off
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            core_run <= 1'b0;
        end else begin
            core_run <= boot_started && !boot_hold;
        end
    end

    // Overlay selects for program and data space
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            program_overlay_select <= OVL_INTERNAL;
            data_overlay_select    <= OVL_INTERNAL;
        end else if (reg_wr && reg_addr == OFS_PM_OVLAY) begin
            program_overlay_select <= reg_wdata[1:0];
        end else if (reg_wr && reg_addr == OFS_DM_OVLAY) begin
            data_overlay_select <= reg_wdata[1:0];
        end
    end

    // Data and I/O wait counts share one register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            data_space_wait_count <= '0;
            io_region_wait_counts <= '0;
        end else if (reg_wr && reg_addr == OFS_WAIT) begin
            data_space_wait_count <= reg_wdata[14:12];
            io_region_wait_counts <= reg_wdata[11:0];
        end
    end

    // Composite enables and boot select disable
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            composite_select_enables <= CMS_EN_RESET;
            bms_disable              <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_CMS_EN) begin
            composite_select_enables <= reg_wdata[3:0];
        end else if (reg_wr && reg_addr == OFS_SYSCTL) begin
            bms_disable <= reg_wdata[SYSCTL_BMS_DIS];
        end
    end

    // Flag direction and output value
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_dir_out <= 1'b0;
            flag_val     <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_FLAG) begin
            flag_dir_out <= reg_wdata[1];
            flag_val     <= reg_wdata[0];
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_STATUS:   reg_rdata <= {13'h0, src_host, no_autoboot, mode_host};
                OFS_PM_OVLAY: reg_rdata <= {14'h0, program_overlay_select};
                OFS_DM_OVLAY: reg_rdata <= {14'h0, data_overlay_select};
                OFS_WAIT:     reg_rdata <= {1'b0, data_space_wait_count,
                                            io_region_wait_counts};
                OFS_CMS_EN:   reg_rdata <= {12'h0, composite_select_enables};
                OFS_SYSCTL:   reg_rdata <= {12'h0, bms_disable, 3'h0};
                OFS_FLAG:     reg_rdata <= {13'h0, shared_flag_pin_in, flag_dir_out,
                                            flag_val};
                OFS_BOOT:     reg_rdata <= {8'h0, boot_hold, boot_cnt, 1'b0};
                default:      reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Shared flag pin: never driven during reset, general flag afterwards
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shared_flag_pin_oe  <= 1'b0;
            shared_flag_pin_out <= 1'b0;
        end else begin
            shared_flag_pin_oe  <= flag_dir_out;
            shared_flag_pin_out <= flag_val;
        end
    end

    // Decode of the request: external hit, wait count, select and address
    always_comb begin
        ovl       = (acc_space == SP_PM) ? program_overlay_select : data_overlay_select;
        in_win    = (acc_addr >= OVL_WIN_LO) && (acc_addr <= OVL_WIN_HI);
        io_region = acc_addr[IO_REGION_LSB+1:IO_REGION_LSB];
        ext_hit   = 1'b0;
        next_wait = '0;
        next_sel  = 4'h0;
        next_addr = '0;
        case (acc_space)
            SP_PM, SP_DM: begin
                // Internal data accesses are never stretched
                if (in_win && (ovl == OVL_EXT1 || ovl == OVL_EXT2)) begin
                    ext_hit = 1'b1;
                    next_sel[acc_space] = 1'b1;
                    if (acc_space == SP_DM) begin
                        next_wait = data_space_wait_count;
                    end
                    if (mode_host) begin
                        next_addr[0] = (ovl == OVL_EXT2);
                    end else begin
                        next_addr = {(ovl == OVL_EXT2), acc_addr[OVL_LSB_W-1:0]};
                    end
                end else if (acc_space == SP_PM && !mode_host && !in_win) begin
                    // Full mode keeps program accesses below the window internal
                    ext_hit = 1'b0;
                end
            end
            SP_BM: begin
                // Still a bus cycle, so the composite select can serve it
                ext_hit = 1'b1;
                next_sel[CMS_BM_BIT] = 1'b1;
                next_addr = acc_addr;
            end
            SP_IO: begin
                ext_hit = 1'b1;
                next_sel[CMS_IO_BIT] = 1'b1;
                next_addr = {3'h0, acc_addr[IO_AW-1:0]};
                next_wait = io_region_wait_counts[io_region*WAIT_W +: WAIT_W];
            end
            default: ;
        endcase
    end

    // Access sequencer with wait-state counting and bus-request gating
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st                     <= MMD_IDLE;
            wcnt                   <= '0;
            acc_done               <= 1'b0;
            ext_addr               <= '0;
            program_space_select_n <= 1'b1;
            data_space_select_n    <= 1'b1;
            boot_space_select_n    <= 1'b1;
            io_space_select_n      <= 1'b1;
            composite_select_n     <= 1'b1;
        end else begin
            acc_done <= 1'b0;
            case (st)
                MMD_IDLE: begin
                    if (acc_req && !bus_request) begin
                        if (ext_hit) begin
                            ext_addr               <= next_addr;
                            program_space_select_n <= !next_sel[CMS_PM_BIT];
                            data_space_select_n    <= !next_sel[CMS_DM_BIT];
                            boot_space_select_n    <= !next_sel[CMS_BM_BIT] ||
                                                      bms_disable;
                            io_space_select_n      <= !next_sel[CMS_IO_BIT];
                            composite_select_n     <= !(|(next_sel &
                                                      composite_select_enables));
                            wcnt <= next_wait;
                            st   <= (next_wait == '0) ? MMD_DONE : MMD_WAIT;
                        end else begin
                            acc_done <= 1'b1;
                        end
                    end
                end
                MMD_WAIT: begin
                    wcnt <= wcnt - 3'h1;
                    if (wcnt == 3'h1) begin
                        st <= MMD_DONE;
                    end
                end
                MMD_DONE: begin
                    acc_done               <= 1'b1;
                    program_space_select_n <= 1'b1;
                    data_space_select_n    <= 1'b1;
                    boot_space_select_n    <= 1'b1;
                    io_space_select_n      <= 1'b1;
                    composite_select_n     <= 1'b1;
                    st                     <= MMD_IDLE;
                end
                default: st <= MMD_IDLE;
            endcase
        end
    end
endmodule

// ==== tb/mmd_decode_chk.sv ====
// Purpose: Port checker for the memory decode block
// Assumes: One clock, reset low and asynchronous
// Notes:   Tracks accepted core requests in helper logic
`timescale 1ns/100ps
module mmd_decode_chk
    import mmd_pkg::*;
#(
    parameter int BOOT_LEN = BOOT_WORDS
) (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              arst_n,
    // Block inputs
    input wire logic              reg_wr,
    input wire logic              acc_req,
    input wire logic [1:0]        acc_space,
    input wire logic [ADDR_W-1:0] acc_addr,
    input wire logic              bus_request,
    // Block outputs
    input wire logic              shared_flag_pin_oe,
    input wire logic              acc_done,
    input wire logic              core_run,
    input wire logic              program_space_select_n,
    input wire logic              data_space_select_n,
    input wire logic              boot_space_select_n,
    input wire logic              io_space_select_n,
    input wire logic              composite_select_n
);
    logic busy;
    logic acc_ok;
    logic idle;
    // Request taken only when idle and the bus is free
    assign acc_ok = acc_req && !bus_request && !busy;
    assign idle   = program_space_select_n && data_space_select_n && boot_space_select_n
                    && io_space_select_n && composite_select_n;
    // Busy from acceptance to completion
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
        end else if (acc_ok) begin
            busy <= 1'b1;
        end else if (acc_done) begin
            busy <= 1'b0;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_io_go;
        acc_ok && acc_space == 2'd3;
    endsequence
    sequence s_dm_int;
        acc_ok && acc_space == 2'd1 && acc_addr < OVL_WIN_LO;
    endsequence
    quiet_release_a: assert property ($rose(arst_n) |-> idle && !shared_flag_pin_oe)
        else $error("select or flag driver active at release");
    bus_gate_a: assert property (bus_request && !busy |=> idle)
        else $error("select while bus requested");
    io_stretch_a: assert property (s_io_go |=> !io_space_select_n)
        else $error("io select too short");
    io_bound_a: assert property (s_io_go |-> ##[2:9] acc_done)
        else $error("io access too long");
    int_fast_a: assert property (s_dm_int |-> ##[1:2] acc_done)
        else $error("internal access slow");
    int_quiet_a: assert property (s_dm_int |=> data_space_select_n [*2])
        else $error("internal access selected bus");
    done_cause_a: assert property (acc_done |-> busy)
        else $error("done without request");
    run_hold_a: assert property (core_run |=> core_run)
        else $error("execution dropped");
    cms_start_a: assert property ($fell(composite_select_n) |-> $past(acc_ok))
        else $error("composite select mistimed");
    flag_cause_a: assert property ($rose(shared_flag_pin_oe) |-> $past(reg_wr, 2))
        else $error("flag driver on without write");
endmodule

bind mmd_decode mmd_decode_chk #(.BOOT_LEN(BOOT_LEN)) mmd_decode_chk_i (
    .clk_sys, .arst_n, .reg_wr, .acc_req, .acc_space, .acc_addr, .bus_request,
    .shared_flag_pin_oe, .acc_done, .core_run, .program_space_select_n,
    .data_space_select_n, .boot_space_select_n, .io_space_select_n, .composite_select_n
);

// ==== tb/mmd_ext_side.sv ====
// Purpose: Strap driver and select logger on the parallel bus
// Assumes: Selects active low
// Notes:   Logs selects, low cycles and address of each access
`timescale 1ns/100ps
module mmd_ext_side
    import mmd_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // Strap level and core request
    input  wire logic              strap_lvl,
    input  wire logic              acc_req,
    // Bus pins, composite first
    input  wire logic [4:0]        sel_n,
    input  wire logic [ADDR_W-1:0] ext_addr,
    // Driver and logs
    output logic                   drv_oe,
    output logic                   drv_val,
    output logic [4:0]             seen,
    output logic [4:0]             low_cnt,
    output logic [ADDR_W-1:0]      addr_seen
);
    // Drives the strap only while reset is low
    assign drv_oe  = !arst_n;
    assign drv_val = strap_lvl;
    // Clear on request, then log the access
    always @(posedge clk_sys) begin
        if (acc_req) begin
            seen    <= 5'h0;
            low_cnt <= 5'h0;
        end else if (sel_n != 5'h1f) begin
            seen      <= seen | ~sel_n;
            low_cnt   <= low_cnt + 5'h1;
            addr_seen <= ext_addr;
        end
    end
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the memory decode block
// Assumes: 10 MHz clock, reset low for 3 cycles
// Notes:   Boot length cut to 4 words
`timescale 1ns/100ps
module tb;
    import mmd_pkg::*;
    localparam int BW = 4;
    logic clk_sys = 1'b0, arst_n = 1'b0, strap_lvl = 1'b0, flag_ext = 1'b1;
    logic strap_autoboot_n = 1'b0, strap_boot_src = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic acc_req = 1'b0, bus_request = 1'b0, boot_word_loaded = 1'b0, host_pm0_write = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata;
    logic [1:0] acc_space = 2'h0;
    logic [13:0] acc_addr = 14'h0, ext_addr, addr_seen;
    logic acc_done, core_run, shared_flag_pin_out, shared_flag_pin_oe, drv_oe, drv_val;
    logic program_space_select_n, data_space_select_n, boot_space_select_n;
    logic io_space_select_n, composite_select_n;
    logic [4:0] seen, low_cnt;
    wire logic flag_pin;
    int n_fail = 0, checks = 0;
    int seed = 32'h30a6deef;
    int cb [4] = '{CMS_PM_BIT, CMS_DM_BIT, CMS_BM_BIT, CMS_IO_BIT};
    // Pin level from both drivers, else the released level
    assign flag_pin = shared_flag_pin_oe ? shared_flag_pin_out : drv_oe ? drv_val : flag_ext;
    always #50 clk_sys = ~clk_sys;
    mmd_decode #(.BOOT_LEN(BW)) mmd_decode_i (
        .clk_sys, .arst_n, .shared_flag_pin_in(flag_pin), .shared_flag_pin_out,
        .shared_flag_pin_oe, .strap_autoboot_n, .strap_boot_src, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .acc_req, .acc_space, .acc_addr, .bus_request,
        .acc_done, .boot_word_loaded, .host_pm0_write, .core_run, .ext_addr,
        .program_space_select_n, .data_space_select_n, .boot_space_select_n,
        .io_space_select_n, .composite_select_n
    );
    mmd_ext_side mmd_ext_side_i (
        .clk_sys, .arst_n, .strap_lvl, .acc_req, .ext_addr, .drv_oe, .drv_val, .seen,
        .low_cnt, .addr_seen, .sel_n({composite_select_n, io_space_select_n,
        boot_space_select_n, data_space_select_n, program_space_select_n})
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // One boot progress pulse, host write or loaded word
    task automatic pw(input logic h);
        @(posedge clk_sys);
        host_pm0_write   <= h;
        boot_word_loaded <= !h;
        @(posedge clk_sys);
        host_pm0_write   <= 1'b0;
        boot_word_loaded <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic acc(input logic [1:0] sp, input logic [13:0] a, input int lim,
                       output logic done);
        @(posedge clk_sys);
        acc_req   <= 1'b1;
        acc_space <= sp;
        acc_addr  <= a;
        @(posedge clk_sys);
        acc_req <= 1'b0;
        done = 1'b0;
        for (int k = 0; k < lim && !done; k++) begin
            @(posedge clk_sys);
            done = acc_done;
        end
        @(posedge clk_sys);
    endtask
    // Straps set during reset, moved away at release
    task automatic do_reset(input logic [2:0] m);
        @(posedge clk_sys);
        arst_n           <= 1'b0;
        strap_lvl        <= m[2];
        flag_ext         <= ~m[2];
        strap_autoboot_n <= m[1];
        strap_boot_src   <= m[0];
        repeat (3) @(posedge clk_sys);
        arst_n           <= 1'b1;
        strap_autoboot_n <= ~m[1];
        strap_boot_src   <= ~m[0];
        repeat (2) @(posedge clk_sys);
    endtask
    // Expected {composite, io, boot, data, program} activity
    function automatic logic [4:0] exp_sel(input logic [1:0] sp, input logic [13:0] a,
            input logic [1:0] ov, input logic [3:0] en, input logic sc);
        logic [3:0] one;
        one = (sp == 2'd2 && sc) ? 4'h0 : 4'h1 << sp;
        return (sp[1] || (a[13] && ov != OVL_INTERNAL)) ? {en[cb[sp]], one} : 5'h0;
    endfunction
    function automatic logic [4:0] exp_cnt(input logic [1:0] sp, input logic [13:0] a,
            input logic [15:0] w);
        return 5'd1 + (sp == 2'd3 ? 5'(w[3 * a[10:9] +: 3]) : 5'(w[14:12]));
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Limit far above the thousand or so cycles the tests need
    initial begin
        #(20_000 * 100);
        n_fail++;
        close_out;
    end
    initial begin
        logic [2:0] md [4];
        logic [15:0] d, w;
        logic [4:0] e;
        logic [3:0] en;
        logic [1:0] sp, ov;
        logic [13:0] a;
        logic dn, sc;
        md = '{3'b000, 3'b010, 3'b100, 3'b101};
        foreach (md[i]) begin
            do_reset(md[i]);
            rd(OFS_STATUS, d);
            chk(16'(d[2:0]), 16'({md[i][0], md[i][1], md[i][2]}), "straps");
            chk(16'(core_run), 16'(md[i] == 3'b010), "free run");
            if (md[i] != 3'b010) begin
                repeat (BW - 1) pw(1'b0);
                chk(16'(core_run), 16'h0, "early run");
                pw(1'b0);
                chk(16'(core_run), 16'(md[i] != 3'b101), "boot end");
                pw(1'b1);
                chk(16'(core_run), 16'h1, "host boot end");
            end
            $display("boot mode %0d done", i);
        end
        do_reset(3'b010);
        wr(OFS_FLAG, 16'h0003);
        @(posedge clk_sys);
        #1;
        chk(16'({shared_flag_pin_oe, shared_flag_pin_out}), 16'h3, "flag out");
        wr(OFS_FLAG, 16'h0000);
        flag_ext <= 1'($random(seed));
        rd(OFS_FLAG, d);
        chk(16'(d[2]), 16'(flag_ext), "flag in");
        rd(OFS_CMS_EN, d);
        chk(16'(d[3:0]), 16'(4'hf & ~(4'h1 << CMS_BM_BIT)), "cms reset");
        $display("flag and reset values done");
        for (int i = 0; i < 48; i++) begin
            w  = 16'($random(seed));
            en = 4'($random(seed));
            sc = 1'($random(seed));
            sp = 2'($random(seed));
            ov = 2'($unsigned($random(seed)) % 3);
            a  = 14'($random(seed));
            a[13] = a[13] | (i % 4 != 0);
            wr(OFS_WAIT, {1'b0, w[14:0]});
            wr(OFS_CMS_EN, {12'h0, en});
            wr(OFS_SYSCTL, {12'h0, sc, 3'h0});
            wr(OFS_PM_OVLAY + {3'h0, sp[0]}, {14'h0, ov});
            acc(sp, a, 20, dn);
            e = exp_sel(sp, a, ov, en, sc);
            chk(16'(dn), 16'h1, "done");
            chk(16'(seen), 16'(e), "selects");
            if (sp[0] && e != 5'h0) chk(16'(low_cnt), 16'(exp_cnt(sp, a, w)), "waits");
            if (!sp[1] && e != 5'h0) chk(16'(addr_seen), 16'({ov == OVL_EXT2, a[12:0]}), "ovl");
            if (sp == 2'd3) chk(16'(addr_seen[10:0]), 16'(a[10:0]), "io addr");
        end
        $display("random accesses done");
        bus_request <= 1'b1;
        acc(2'd3, 14'h0123, 6, dn);
        chk(16'({dn, seen}), 16'h0, "bus held");
        bus_request <= 1'b0;
        $display("bus request done");
        do_reset(3'b101);
        wr(OFS_DM_OVLAY, 16'h0002);
        acc(2'd1, 14'h2abc, 20, dn);
        chk(16'({dn, addr_seen}), 16'h4001, "host ovl");
        chk(16'(seen), 16'h0012, "host selects");
        $display("host mode done");
        close_out;
    end
endmodule
